// file: hdl/wdog_cfg_top.sv
// apb-visible watchdog driven by the configuration word fields
`timescale 1ns/1ps
module wdog_cfg_top
   import wdog_cfg_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             wdog_reset_out,
   output logic             wdog_running
);
   import wdog_cfg_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] cfg;
      logic        sw_en;
      wd_state_t   state;
      logic [35:0] count;
      logic        early_fault;
      logic        timeout_fault;
      logic [6:0]  pulse;
      logic [31:0] rdata;
   } st_t;

   st_t cur_reg, cur_next;

   logic       hw_en, win_dis;
   logic [4:0] ps_sel;
   logic [1:0] win_sz;
   logic [2:0] open8;

   wdog_cfg_decode u_dec (
      .cfg_word              (cur_reg.cfg),
      .wdog_hw_enable        (hw_en),
      .wdog_window_disable   (win_dis),
      .wdog_postscale_select (ps_sel),
      .wdog_window_size      (win_sz),
      .open_eighths          (open8)
   );

   // period in clocks: base ticks shifted by postscale
   function automatic logic [35:0] period_of(input logic [4:0] ps);
      period_of = {20'h0, BASE_TICKS} << ps;
   endfunction

   logic [35:0] period;
   logic [38:0] win_start;
   logic        enabled, wr, rd, service;

   always_comb begin
      period    = period_of(ps_sel);
      // window opens at (1 - open/8) of the period
      win_start = {3'h0, period} * 39'(8 - open8);
      enabled   = hw_en | cur_reg.sw_en;
      wr        = psel & penable & pwrite;
      rd        = psel & ~penable & ~pwrite;                  // read setup cycle
      service   = wr & (paddr == CTRL_OFFSET) & pwdata[CTRL_SERVICE_BIT];
   end

   // ------------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      cur_next = cur_reg;
      // registers; the config word models programming, reserved forced
      if (wr && paddr == CFG_OFFSET) begin
         cur_next.cfg = pwdata | CFG_RESERVED_MASK;
      end
      if (wr && paddr == CTRL_OFFSET) begin
         cur_next.sw_en = pwdata[CTRL_SW_EN_BIT];
      end
      if (wr && paddr == STATUS_OFFSET) begin
         cur_next.early_fault   = cur_reg.early_fault & ~pwdata[0];
         cur_next.timeout_fault = cur_reg.timeout_fault & ~pwdata[1];
      end
      case (cur_reg.state)
         WD_OFF: begin
            cur_next.count = '0;
            if (enabled) begin
               cur_next.state = WD_RUN;
            end
         end
         WD_RUN: begin
            if (!enabled) begin
               cur_next.state = WD_OFF;
            end else if (service) begin
               // early service in windowed mode is a fault
               if (!win_dis && {cur_reg.count, 3'h0} < win_start) begin
                  cur_next.early_fault = 1'b1;
                  cur_next.state       = WD_FIRE;
                  cur_next.pulse       = RESET_PULSE_CYCLES;
               end else begin
                  cur_next.count = '0;
               end
            end else if (cur_reg.count >= period - 36'h1) begin
               cur_next.timeout_fault = 1'b1;
               cur_next.state         = WD_FIRE;
               cur_next.pulse         = RESET_PULSE_CYCLES;
            end else begin
               cur_next.count = cur_reg.count + 36'h1;
            end
         end
         WD_FIRE: begin
            cur_next.count = '0;
            if (cur_reg.pulse == 7'h1) begin
               cur_next.state = WD_OFF;
               cur_next.sw_en = 1'b0;  // the reset it raises clears software enable
            end
            cur_next.pulse = cur_reg.pulse - 7'h1;
         end
         default: cur_next.state = WD_OFF;
      endcase
      // read data captured in the setup cycle so the access cycle answers
      // from a flip-flop; status and count are a snapshot one clock early
      if (rd) begin
         case (paddr)
            CFG_OFFSET:    cur_next.rdata = cur_reg.cfg;
            CTRL_OFFSET:   cur_next.rdata = {31'h0, enabled};
            STATUS_OFFSET: cur_next.rdata = {28'h0, win_dis, hw_en,
                                             cur_reg.timeout_fault, cur_reg.early_fault};
            COUNT_OFFSET:  cur_next.rdata = cur_reg.count[31:0];
            default:       cur_next.rdata = 32'h0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_reg       <= '0;
         cur_reg.cfg   <= CFG_RESET_VALUE;
         cur_reg.state <= WD_OFF;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // zero-wait slave: the setup cycle already registered the read word,
   // so no wait state is needed and prdata never glitches with paddr
   always_comb begin
      pready  = 1'b1;
      pslverr = psel & penable & (paddr[11:4] != 8'h0 || paddr[1:0] != 2'b00);
      prdata  = cur_reg.rdata;
      wdog_reset_out = (cur_reg.state == WD_FIRE);
      wdog_running   = (cur_reg.state == WD_RUN);
   end
endmodule

// file: hdl/wdog_cfg_pkg.sv
// constants, register map and types for the watchdog configuration decoder
// ------------------------------------------------------------------
// ------------------------------------------------------------------
package wdog_cfg_pkg;

   // ---------------------------------------------------------------
   // register byte addresses
   // ---------------------------------------------------------------
   localparam logic [11:0] CFG_OFFSET    = 12'h000;
   localparam logic [11:0] CTRL_OFFSET   = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;
   localparam logic [11:0] COUNT_OFFSET  = 12'h00c;

   // ---------------------------------------------------------------
   // configuration word field positions
   // ---------------------------------------------------------------
   localparam int WIN_SIZE_LSB  = 24;
   localparam int HW_EN_BIT     = 23;
   localparam int WIN_DIS_BIT   = 22;
   localparam int POSTSCALE_LSB = 16;

   // reserved bits must be ones; erased word is all ones
   localparam logic [31:0] CFG_RESERVED_MASK = 32'hfc20_0000;
   localparam logic [31:0] CFG_RESET_VALUE   = 32'hffff_ffff;

   // control register bits
   localparam int CTRL_SW_EN_BIT   = 0;
   localparam int CTRL_SERVICE_BIT = 1;

   // service key and base tick count
   localparam logic [31:0] SERVICE_KEY   = 32'h0000_5743;
   localparam logic [4:0]  POSTSCALE_MAX = 5'h14;
   localparam logic [15:0] BASE_TICKS    = 16'h0004;
   localparam logic [6:0]  RESET_PULSE_CYCLES = 7'h04;

   typedef enum logic [1:0] {
      WD_OFF     = 2'b00,
      WD_RUN     = 2'b01,
      WD_FIRE    = 2'b11
   } wd_state_t;

endpackage

// file: hdl/wdog_cfg_decode.sv
// combinational decoder of the watchdog fields of the configuration word
`timescale 1ns/1ps
module wdog_cfg_decode
   import wdog_cfg_pkg::*;
(
   input  wire logic [31:0] cfg_word,
   output logic             wdog_hw_enable,
   output logic             wdog_window_disable,
   output logic [4:0]       wdog_postscale_select,
   output logic [1:0]       wdog_window_size,
   output logic [2:0]       open_eighths
);
   // ------------------------------------------------------------------
   // field extraction
   // ------------------------------------------------------------------
   always_comb begin
      wdog_hw_enable      = cfg_word[HW_EN_BIT];
      wdog_window_disable = cfg_word[WIN_DIS_BIT];
      wdog_window_size    = cfg_word[WIN_SIZE_LSB +: 2];
      // out-of-range codes clamp to the largest ratio
      if (cfg_word[POSTSCALE_LSB +: 5] > POSTSCALE_MAX) begin
         wdog_postscale_select = POSTSCALE_MAX;
      end else begin
         wdog_postscale_select = cfg_word[POSTSCALE_LSB +: 5];
      end
      // window open fraction of the period, in eighths (37.5% = 3/8)
      case (wdog_window_size)
         2'b11:   open_eighths = 3'h2;
         2'b10:   open_eighths = 3'h3;
         2'b01:   open_eighths = 3'h4;
         default: open_eighths = 3'h6;
      endcase
   end
endmodule

// file: tb/wdog_cfg_assertions.sv
// port-level checker for the watchdog top
`timescale 1ns/1ps
module wdog_cfg_assertions
   import wdog_cfg_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        wdog_reset_out,
   input wire logic        wdog_running
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic        acc;
   logic        bad;
   logic        ctl_wr;
   logic [31:0] cfg_q;
   // ---------------------------------------------------------------
   // shadow of the programmed word, reserved bits read back as ones
   // ---------------------------------------------------------------
   assign acc = psel && penable;
   assign bad = paddr > 12'h00c || paddr[1:0] != 2'b00;
   assign ctl_wr = acc && pwrite && paddr == CTRL_OFFSET;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cfg_q <= CFG_RESET_VALUE;
      else if (acc && pwrite && paddr == CFG_OFFSET) cfg_q <= pwdata | CFG_RESERVED_MASK;
   end
   ready_high_a: assert property (pready) else $error("pready low");
   map_err_a: assert property (acc && bad |-> pslverr) else $error("no slverr");
   map_ok_a: assert property (acc && !bad |-> !pslverr) else $error("bad slverr");
   bad_read_a: assert property (acc && !pwrite && bad |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   cfg_read_a: assert property (acc && !pwrite && paddr == CFG_OFFSET |-> prdata == cfg_q)
      else $error("config readback wrong");
   pulse_len_a: assert property ($rose(wdog_reset_out) |-> wdog_reset_out[*4] ##1 !wdog_reset_out)
      else $error("reset pulse length wrong");
   boot_run_a: assert property ($rose(presetn) |-> ##[0:2] wdog_running)
      else $error("not running after reset");
   hw_lock_a: assert property (ctl_wr && cfg_q[HW_EN_BIT] && wdog_running
      |=> wdog_running || wdog_reset_out) else $error("software stopped forced watchdog");
   sw_off_a: assert property (ctl_wr && !cfg_q[HW_EN_BIT] && !pwdata[0]
      |-> ##[1:2] !wdog_running) else $error("software disable ignored");
   cover property ($rose(wdog_reset_out));
   cover property (acc && bad);
   cover property (ctl_wr && cfg_q[HW_EN_BIT]);
endmodule
bind wdog_cfg_top wdog_cfg_assertions chk_u (.*);

// file: tb/tb.sv
// self-checking bench for the watchdog top
`timescale 1ns/1ps
module tb;
   import wdog_cfg_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rst_o, run_o, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          num_errors, compares, n, k, t[4];
   int          open8[4] = '{6, 4, 3, 2};
   wdog_cfg_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wdog_reset_out(rst_o), .wdog_running(run_o));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ---------------------------------------------------------------
   // shared tasks: verdict, compare, apb master, bounded waits
   // ---------------------------------------------------------------
   task automatic test_done();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // idle edge at the end keeps psel from being driven twice in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0);
      if (n >= 50) test_done();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_rst(input logic lvl);
      n = 0;
      while (rst_o !== lvl && n < 5000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 5000) chk(32'h1, 32'h0);
      if (n >= 5000) test_done();
   endtask
   // wait for a fire so the count restarts at a known edge, clear faults,
   // idle kk cycles, service, read status
   task automatic trial(input int kk);
      wait_rst(1'b1);
      wait_rst(1'b0);
      apb(1'b1, STATUS_OFFSET, 32'h3);
      repeat (kk) @(posedge pclk);
      apb(1'b1, CTRL_OFFSET, SERVICE_KEY);
      apb(1'b0, STATUS_OFFSET, 32'h0);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      apb(1'b0, CFG_OFFSET, 32'h0);
      chk(rd, 32'hffff_ffff);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd[3:2], 2'b11);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, CFG_OFFSET, 32'h0);
      apb(1'b0, CFG_OFFSET, 32'h0);
      chk(rd, 32'hfc20_0000);
      $display("test regs done");
   endtask
   task automatic t_enable();
      apb(1'b1, CTRL_OFFSET, 32'h0);
      apb(1'b1, CFG_OFFSET, 32'h0048_0000 | CFG_RESERVED_MASK);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk({rd[0], run_o}, 2'b00);
      apb(1'b1, CTRL_OFFSET, 32'h1);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk({rd[0], run_o}, 2'b11);
      apb(1'b1, CFG_OFFSET, 32'h00c8_0000 | CFG_RESERVED_MASK);
      apb(1'b1, CTRL_OFFSET, 32'h0);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk({rd[0], run_o}, 2'b11);
      $display("test enable done");
   endtask
   // timeout length from service to reset pulse, postscale 0 to 3
   task automatic t_post();
      for (int p = 0; p < 4; p++) begin
         apb(1'b1, CFG_OFFSET, 32'h00c0_0000 | CFG_RESERVED_MASK | (p << 16));
         apb(1'b1, CTRL_OFFSET, SERVICE_KEY);
         wait_rst(1'b1);
         wait_rst(1'b0);
         apb(1'b1, CTRL_OFFSET, SERVICE_KEY);
         wait_rst(1'b1);
         t[p] = n;
         chk(t[p], 32'(BASE_TICKS) << p);
      end
      $display("test postscale done");
   endtask
   // earliest clean service per window code, relative to code 00
   task automatic t_window();
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, CFG_OFFSET, (c << 24) | 32'h0083_0000 | CFG_RESERVED_MASK);
         k = 0;
         do begin
            trial(k);
            k++;
         end while (rd[0] !== 1'b0 && k < 40);
         t[c] = k;
         // window opening moves by period * (open8 of code 00 - open8 of code c) / 8
         chk(t[c] - t[0], ((32'(BASE_TICKS) << 3) * (open8[0] - open8[c])) / 8);
      end
      chk(t[0] > 1, 1'b1);
      apb(1'b1, CFG_OFFSET, 32'h00c3_0000 | CFG_RESERVED_MASK);
      trial(0);
      chk(rd[0], 1'b0);
      $display("test window done");
   endtask
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      num_errors = 0;
      compares = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_enable();
      t_post();
      t_window();
      test_done();
   end
endmodule
